// ===== hdl/etc_tx_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module etc_tx_ctrl #(
  parameter logic [15:0] BUF_BYTES = etc_pkg::ETC_BUF_BYTES
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire etc_pkg::etc_reg_req_s reg_req,
  output logic [15:0] reg_rdata,
  input wire logic [15:0] buf_free,
  input wire logic data_wr,
  input wire logic data_late,
  input wire etc_pkg::etc_line_res_s line_res,
  input wire logic pulse_valid,
  input wire logic pulse_bad,
  input wire logic crs_in,
  input wire logic col_in,
  output logic tx_irq,
  output logic tx_go,
  output logic [15:0] tx_wire_len,
  output logic tx_add_crc,
  output logic tx_flush,
  output logic data_accept,
  output logic link_good,
  output logic link_pulse_en,
  output logic enc_to_dec,
  output logic line_drv_en,
  output logic col_seen
);
  import etc_pkg::*;
  // one state at a time: idle, bid waiting for room, filling, sending
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_WAIT = 4'b0010,
    ST_FILL = 4'b0100,
    ST_SEND = 4'b1000
  } etc_state_e;
  // every register of the block but link_q and the link monitor state inside u_link lives in
  // this one struct, so the whole next state is built in one process and cannot drift apart
  typedef struct packed {
    etc_state_e fsm;
    logic [15:0] cmd;
    logic [15:0] len;
    logic [15:0] wire_len;
    logic add_crc;
    logic [15:0] loaded;
    logic bid_ok;
    logic committed;
    logic ready_now;
    logic bid_err;
    logic ready_evt;
    logic underrun;
    logic tx_ok;
    logic excoll;
    logic jabber;
    logic late;
    logic ok_irq_en;
    logic rdy_irq_en;
    logic auto_sw;
    logic [15:0] test_ctl;
    logic [15:0] rdata;
    logic irq;
    logic go;
    logic flush;
    logic lp_en;
    logic e2d;
    logic drv_en;
    logic col;
  } etc_tx_s;
  etc_tx_s st, next_st;
  logic send_ok;
  logic [15:0] calc_len;
  logic calc_crc;
  logic lm_good;

  // the request addresses the given register offset this cycle
  function automatic logic hit(input etc_reg_req_s r, input logic [15:0] a);
    hit = r.addr == a;
  endfunction

  // preamble threshold picked by the two start bits; a frame shorter than
  // the threshold goes once it is whole, or it would never leave
  function automatic logic [15:0] start_at(input logic [15:0] c,
                                           input logic [15:0] l);
    case ({c[ETC_B_START_HI], c[ETC_B_START_LO]})
      2'b00: start_at = ETC_START_5;
      2'b10: start_at = ETC_START_381;
      2'b01: start_at = ETC_START_1021;
      default: start_at = l;
    endcase
    if (start_at > l) begin
      start_at = l;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // the length word is judged straight off the bus, so the verdict is
  // ready in the very cycle of the write and needs no extra state
  etc_len_check u_len (
    .req_len(reg_req.wdata),
    .pad_disable(st.cmd[ETC_B_PAD_DIS]),
    .crc_inhibit(st.cmd[ETC_B_CRC_INH]),
    .send_ok(send_ok),
    .wire_len(calc_len),
    .add_crc(calc_crc)
  );

  // link pulse integrity runs on its own, it shares no state with bids
  etc_link_mon u_link (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .pulse_valid(pulse_valid),
    .pulse_bad(pulse_bad),
    .link_good(lm_good)
  );

  ////////////////////////////////////////////////////////////////////////////
  // main next-state logic
  always_comb begin
    logic wr;
    logic rd;
    logic room;
    wr = reg_req.wr;
    rd = reg_req.rd;
    room = 1'b0;
    next_st = st;
    next_st.go = 1'b0;
    next_st.flush = 1'b0;
    room = buf_free >= st.wire_len;

    // configuration registers
    if (wr && hit(reg_req, ETC_OFS_TX_CFG)) begin
      next_st.ok_irq_en = reg_req.wdata[ETC_B_TX_OK];
    end
    if (wr && hit(reg_req, ETC_OFS_BUF_CFG)) begin
      next_st.rdy_irq_en = reg_req.wdata[ETC_B_READY];
    end
    if (wr && hit(reg_req, ETC_OFS_TEST_CTL)) begin
      next_st.test_ctl = reg_req.wdata;
      next_st.auto_sw = reg_req.wdata[ETC_B_AUTO_SW];
    end

    // reads: event registers clear on read, a same-cycle set wins below
    if (rd && hit(reg_req, ETC_OFS_TX_EVENT)) begin
      next_st.tx_ok = 1'b0;
      next_st.excoll = 1'b0;
      next_st.jabber = 1'b0;
      next_st.late = 1'b0;
    end
    if (rd && hit(reg_req, ETC_OFS_BUF_EVENT)) begin
      next_st.ready_evt = 1'b0;
      next_st.underrun = 1'b0;
      if (st.ready_evt && st.bid_ok && st.fsm == ST_WAIT) begin
        next_st.committed = 1'b1;
        next_st.fsm = ST_FILL;
      end
    end
    if (rd && hit(reg_req, ETC_OFS_BUS_ST)) begin
      if (st.ready_now && st.bid_ok && st.fsm == ST_WAIT) begin
        next_st.committed = 1'b1;
        next_st.fsm = ST_FILL;
      end
    end

    // command write starts a fresh bid; the force bit aborts everything
    if (wr && hit(reg_req, ETC_OFS_TX_CMD)) begin
      next_st.cmd = reg_req.wdata;
      next_st.bid_ok = 1'b0;
      next_st.ready_now = 1'b0;
      if (reg_req.wdata[ETC_B_FORCE]) begin
        next_st.committed = 1'b0;
        next_st.flush = 1'b1;
        next_st.fsm = ST_IDLE;
        next_st.loaded = '0;
      end else if (st.fsm == ST_WAIT) begin
        // a fresh command drops a bid that never got its space, otherwise
        // the next length write would be refused for good
        next_st.fsm = ST_IDLE;
      end
    end

    // length write checks the bid; the force bit blocks it, as the host
    // is expected to pair an abort with a zero length
    if (wr && hit(reg_req, ETC_OFS_TX_LENGTH) && !st.cmd[ETC_B_FORCE] &&
        st.fsm == ST_IDLE) begin
      if (send_ok) begin
        next_st.len = reg_req.wdata;
        next_st.wire_len = calc_len;
        next_st.add_crc = calc_crc;
        next_st.bid_ok = 1'b1;
        next_st.bid_err = 1'b0;
        next_st.loaded = '0;
        next_st.fsm = ST_WAIT;
        if (buf_free >= calc_len) begin
          next_st.ready_now = 1'b1;
        end
      end else begin
        next_st.bid_err = 1'b1;
        next_st.bid_ok = 1'b0;
      end
    end

    // waiting for room; each flag is raised once and then left for the
    // host to read, so free space that comes and goes cannot raise it twice
    if (st.fsm == ST_WAIT && !st.ready_now && !st.ready_evt && room) begin
      if (st.rdy_irq_en) begin
        next_st.ready_evt = 1'b1;
      end else begin
        next_st.ready_now = 1'b1;
      end
    end

    // frame data into committed space only; bytes offered before the commit
    // are dropped, they would land in space another frame may still own
    if (st.fsm == ST_FILL && data_wr && st.committed) begin
      next_st.loaded = st.loaded + 16'h0001;
      if (st.loaded + 16'h0001 >= start_at(st.cmd, st.len)) begin
        next_st.go = 1'b1;
        next_st.fsm = ST_SEND;
      end
    end
    if (st.fsm == ST_SEND && data_wr && st.loaded < st.len) begin
      next_st.loaded = st.loaded + 16'h0001;
    end

    // slow data abandons the frame; a half sent frame cannot be saved, so
    // the space is released at once
    if ((st.fsm == ST_SEND || st.fsm == ST_FILL) && data_late &&
        st.committed) begin
      next_st.underrun = 1'b1;
      next_st.flush = 1'b1;
      next_st.committed = 1'b0;
      next_st.fsm = ST_IDLE;
    end

    // line outcome; the space is freed whatever the result
    // and no retry is made here, the line side owns retries
    if (st.fsm == ST_SEND && line_res.done) begin
      next_st.committed = 1'b0;
      next_st.fsm = ST_IDLE;
      next_st.ready_now = 1'b0;
      if (line_res.ok) begin
        next_st.tx_ok = 1'b1;
      end
      if (line_res.excoll) begin
        next_st.excoll = 1'b1;
      end
      if (line_res.jabber) begin
        next_st.jabber = 1'b1;
      end
      if (line_res.late) begin
        next_st.late = 1'b1;
      end
    end

    // interrupt follows the rising success flag
    // and the ready event stays on the line until the host reads it
    next_st.irq = (next_st.tx_ok && !st.tx_ok && st.ok_irq_en) ||
      (next_st.ready_evt && st.rdy_irq_en);

    // test and media controls; auto switch keeps link pulses off even
    // though that can keep an autonegotiating hub from falling back
    next_st.lp_en = !next_st.auto_sw;
    next_st.e2d = next_st.test_ctl[ETC_B_LOOP_ENDEC];
    next_st.drv_en = !next_st.test_ctl[ETC_B_LOOP_ENDEC];
    // loopback ignores carrier sense, only a true collision counts
    if (next_st.test_ctl[ETC_B_LOOP_ENDEC] ||
        next_st.test_ctl[ETC_B_AUI_LOOP] ||
        next_st.test_ctl[ETC_B_FDX]) begin
      next_st.col = col_in;
    end else begin
      next_st.col = col_in || (crs_in && st.fsm == ST_SEND);
    end

    // read data, registered like every output
    // unknown offsets read as zero so a stray read is harmless
    next_st.rdata = '0;
    if (rd) begin
      case (reg_req.addr)
        ETC_OFS_TX_CMD: next_st.rdata = st.cmd;
        ETC_OFS_BUS_ST: begin
          next_st.rdata[ETC_B_BID_ERR] = st.bid_err;
          next_st.rdata[ETC_B_READY] = st.ready_now;
        end
        ETC_OFS_TX_EVENT: begin
          next_st.rdata[ETC_B_TX_OK] = st.tx_ok;
          next_st.rdata[ETC_B_JABBER] = st.jabber;
          next_st.rdata[ETC_B_LATE] = st.late;
          next_st.rdata[ETC_B_EXCOLL] = st.excoll;
        end
        ETC_OFS_BUF_EVENT: begin
          next_st.rdata[ETC_B_READY] = st.ready_evt;
          next_st.rdata[ETC_B_UNDERRUN] = st.underrun;
        end
        ETC_OFS_TX_CFG: next_st.rdata[ETC_B_TX_OK] = st.ok_irq_en;
        ETC_OFS_BUF_CFG: next_st.rdata[ETC_B_READY] = st.rdy_irq_en;
        ETC_OFS_TEST_CTL: next_st.rdata = st.test_ctl;
        default: next_st.rdata = '0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // reset leaves the link pulses and the line driver on, the states a
  // port needs to come up on its own without any register write
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      st <= '0;
      st.fsm <= ST_IDLE;
      st.lp_en <= 1'b1;
      st.drv_en <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // link status is registered once more so the output is a flop
  logic link_q;
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      link_q <= 1'b0;
    end else begin
      link_q <= lm_good;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // every output is read straight off a flop, link_good off link_q and the rest off the state
  assign reg_rdata = st.rdata;
  assign tx_irq = st.irq;
  assign tx_go = st.go;
  assign tx_wire_len = st.wire_len;
  assign tx_add_crc = st.add_crc;
  assign tx_flush = st.flush;
  assign data_accept = st.committed;
  assign link_good = link_q;
  assign link_pulse_en = st.lp_en;
  assign enc_to_dec = st.e2d;
  assign line_drv_en = st.drv_en;
  assign col_seen = st.col;
endmodule // etc_tx_ctrl
`default_nettype wire

// ===== hdl/etc_pkg.sv
// Notes on behaviour
// - a frame sent without failure sets the success flag in the tx event reg
// - success flag rising with success irq enable set raises the interrupt
// - on a request, if the length fits in free buffer space, set ready-now
// - no room and ready irq enable set: wait for room, then set ready event
// - no room and ready irq enable clear: set ready-now once room appears
// - commit space only after a good request and a read of a ready flag
// - committed space takes no later frame data while it stays committed
// - a line failure sets excess collision, jabber or late collision flag
// - force bit discards the committed frame and all queued frames
// - data arriving too slowly abandons the frame and sets the underrun flag
// - sent length comes from the written length, adjusted by pad and crc bits
// - lengths 3 to 60 pad to 60 unless padding is disabled, even without crc
// - lengths 60 to 1514 are sent, with crc unless crc is inhibited
// - 1514 to 1518 sent only with crc inhibited; above 1518 never sent
// - lengths under 3 bytes are never sent
// - link good after 4 valid link pulses in a row; an invalid one restarts
// - auto media switch mode sends no link pulses on the twisted pair
// - internal test loops encoder into decoder, line driver and receiver off; only line_drv_en drops here, there is no receiver control
// - in loopback, carrier sense is ignored for collision detection
// - a bad length discards the command and sets the bid error flag
// - start field picks preamble after 5, 381, 1021 bytes or whole frame
package etc_pkg;
  localparam logic [15:0] ETC_OFS_TX_CMD = 16'h0144;
  localparam logic [15:0] ETC_OFS_TX_LENGTH = 16'h0146;
  localparam logic [15:0] ETC_OFS_BUS_ST = 16'h0138;
  localparam logic [15:0] ETC_OFS_TX_EVENT = 16'h0128;
  localparam logic [15:0] ETC_OFS_BUF_EVENT = 16'h012C;
  localparam logic [15:0] ETC_OFS_TX_CFG = 16'h0106;
  localparam logic [15:0] ETC_OFS_BUF_CFG = 16'h010A;
  localparam logic [15:0] ETC_OFS_TEST_CTL = 16'h0118;
  // bit positions
  localparam int ETC_B_START_LO = 6;
  localparam int ETC_B_START_HI = 7;
  localparam int ETC_B_FORCE = 8;
  localparam int ETC_B_CRC_INH = 12;
  localparam int ETC_B_PAD_DIS = 13;
  localparam int ETC_B_BID_ERR = 7;
  localparam int ETC_B_READY = 8;
  localparam int ETC_B_UNDERRUN = 9;
  localparam int ETC_B_TX_OK = 8;
  localparam int ETC_B_JABBER = 10;
  localparam int ETC_B_LATE = 13;
  localparam int ETC_B_EXCOLL = 15;
  localparam int ETC_B_LOOP_ENDEC = 9;
  localparam int ETC_B_AUI_LOOP = 10;
  localparam int ETC_B_FDX = 14;
  localparam int ETC_B_AUTO_SW = 8;
  // length bounds in bytes, and the link good pulse count
  localparam logic [15:0] ETC_LEN_MIN = 16'h0003;
  localparam logic [15:0] ETC_LEN_PAD = 16'h003C;
  localparam logic [15:0] ETC_LEN_MAX_CRC = 16'h05EA;
  localparam logic [15:0] ETC_LEN_MAX_RAW = 16'h05EE;
  localparam logic [15:0] ETC_START_5 = 16'h0005;
  localparam logic [15:0] ETC_START_381 = 16'h017D;
  localparam logic [15:0] ETC_START_1021 = 16'h03FD;
  localparam logic [2:0] ETC_LINK_GOOD_CNT = 3'h4;
  localparam logic [15:0] ETC_BUF_BYTES = 16'h0C00;
  // register port bundle
  typedef struct packed {
    logic wr;
    logic rd;
    logic [15:0] addr;
    logic [15:0] wdata;
  } etc_reg_req_s;
  // line side outcome of a frame
  typedef struct packed {
    logic done;
    logic ok;
    logic excoll;
    logic jabber;
    logic late;
  } etc_line_res_s;
endpackage

// ===== hdl/etc_len_check.sv
`timescale 1ns/1ps
`default_nettype none
module etc_len_check (
  input wire logic [15:0] req_len,
  input wire logic pad_disable,
  input wire logic crc_inhibit,
  output logic send_ok,
  output logic [15:0] wire_len,
  output logic add_crc
);
  import etc_pkg::*;
  ////////////////////////////////////////////////////////////////////////////
  // length decision; the bands meet at 60 and 1514, both sides send there
  always_comb begin
    send_ok = 1'b0;
    wire_len = req_len;
    add_crc = !crc_inhibit;
    if (req_len < ETC_LEN_MIN) begin
      send_ok = 1'b0;
    end else if (req_len < ETC_LEN_PAD) begin
      send_ok = 1'b1;
      if (!pad_disable) begin
        wire_len = ETC_LEN_PAD;
      end
    end else if (req_len <= ETC_LEN_MAX_CRC) begin
      send_ok = 1'b1;
    end else if (req_len <= ETC_LEN_MAX_RAW) begin
      send_ok = crc_inhibit;
    end
  end
endmodule // etc_len_check
`default_nettype wire

// ===== hdl/etc_link_mon.sv
`timescale 1ns/1ps
`default_nettype none
module etc_link_mon (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic pulse_valid,
  input wire logic pulse_bad,
  output logic link_good
);
  import etc_pkg::*;
  typedef struct packed {
    logic [2:0] cnt;
    logic good;
  } etc_lm_s;
  etc_lm_s st, next_st;
  ////////////////////////////////////////////////////////////////////////////
  // count valid pulses in a row; a bad one drops the link and restarts
  always_comb begin
    next_st = st;
    if (pulse_bad) begin
      next_st.cnt = 3'h0;
      next_st.good = 1'b0;
    end else if (pulse_valid && !st.good) begin
      next_st.cnt = st.cnt + 3'h1;
      if (st.cnt + 3'h1 == ETC_LINK_GOOD_CNT) begin
        next_st.good = 1'b1;
      end
    end
  end
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
  assign link_good = st.good;
endmodule // etc_link_mon
`default_nettype wire

// ===== test/etc_tx_ctrl_chk.sv
`timescale 1ns/1ps
`default_nettype none
module etc_tx_ctrl_chk #(
  parameter logic [15:0] BUF_BYTES = etc_pkg::ETC_BUF_BYTES
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire etc_pkg::etc_reg_req_s reg_req,
  input wire etc_pkg::etc_line_res_s line_res,
  input wire logic pulse_valid,
  input wire logic pulse_bad,
  input wire logic tx_irq,
  input wire logic tx_go,
  input wire logic [15:0] tx_wire_len,
  input wire logic tx_add_crc,
  input wire logic tx_flush,
  input wire logic data_accept,
  input wire logic link_good,
  input wire logic link_pulse_en,
  input wire logic enc_to_dec,
  input wire logic line_drv_en
);
  import etc_pkg::*;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  logic [2:0] n_valid;
  logic ok_irq_en;
  // valid pulses since the last bad one; saturates so it cannot wrap to 0
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      n_valid <= 3'h0;
      ok_irq_en <= 1'b0;
    end else begin
      if (pulse_bad)
        n_valid <= 3'h0;
      else if (pulse_valid && n_valid != 3'h7)
        n_valid <= n_valid + 3'h1;
      if (reg_req.wr && reg_req.addr == ETC_OFS_TX_CFG)
        ok_irq_en <= reg_req.wdata[ETC_B_TX_OK];
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  a_link_needs_four: assert property ($rose(link_good)
    |-> n_valid >= 3'h4)
    else $error("link good before four valid pulses");
  a_success_irq: assert property (line_res.done && line_res.ok
    && ok_irq_en |-> ##[1:3] tx_irq) else $error("no irq after success");
  a_auto_sw_quiet: assert property (reg_req.wr
    && reg_req.addr == ETC_OFS_TEST_CTL && reg_req.wdata[ETC_B_AUTO_SW]
    |-> ##[1:2] !link_pulse_en) else $error("link pulses in auto switch");
  a_loop_drv_off: assert property (enc_to_dec |-> !line_drv_en)
    else $error("line driver on in internal test");
  a_go_committed: assert property (tx_go |-> data_accept)
    else $error("start without committed space");
  a_go_len_range: assert property (tx_go
    |-> tx_wire_len >= ETC_LEN_MIN && tx_wire_len <= ETC_LEN_MAX_RAW)
    else $error("length out of range");
  a_crc_len_max: assert property (tx_go && tx_add_crc
    |-> tx_wire_len <= ETC_LEN_MAX_CRC) else $error("too long with crc");
  a_flush_drops: assert property (tx_flush |-> ##[0:2] !data_accept)
    else $error("commit held after flush");
endmodule // etc_tx_ctrl_chk
bind etc_tx_ctrl etc_tx_ctrl_chk #(.BUF_BYTES(BUF_BYTES)) i_etc_tx_ctrl_chk (
  .clk_sys(clk_sys), .rst_b(rst_b), .reg_req(reg_req), .line_res(line_res),
  .pulse_valid(pulse_valid), .pulse_bad(pulse_bad), .tx_irq(tx_irq),
  .tx_go(tx_go), .tx_wire_len(tx_wire_len), .tx_add_crc(tx_add_crc),
  .tx_flush(tx_flush), .data_accept(data_accept), .link_good(link_good),
  .link_pulse_en(link_pulse_en), .enc_to_dec(enc_to_dec),
  .line_drv_en(line_drv_en));
`default_nettype wire

// ===== test/etc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module etc_host_model (
  input wire logic clk_sys,
  output var etc_pkg::etc_reg_req_s reg_req,
  input wire logic [15:0] reg_rdata
);
  import etc_pkg::*;
  initial reg_req = '0;
  // accesses launch on the falling edge so the rising edge sees them settled
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(negedge clk_sys);
    reg_req <= '{1'b1, 1'b0, a, d};
    @(negedge clk_sys);
    reg_req <= '0;
  endtask
  // read data is registered, so it is taken one cycle after the strobe
  task automatic rd(input logic [15:0] a, output logic [15:0] d);
    @(negedge clk_sys);
    reg_req <= '{1'b0, 1'b1, a, 16'h0000};
    @(negedge clk_sys);
    reg_req <= '0;
    d = reg_rdata;
  endtask
  // command is rewritten for every frame, even when unchanged
  task automatic request(input logic [15:0] cmd, input logic [15:0] len,
                         output logic [15:0] st);
    wr(ETC_OFS_TX_CMD, cmd);
    wr(ETC_OFS_TX_LENGTH, len);
    rd(ETC_OFS_BUS_ST, st);
  endtask
  // abort always carries a zero length
  task automatic abort();
    logic [15:0] st;
    request(16'h0100, 16'h0000, st);
  endtask
endmodule // etc_host_model
`default_nettype wire

// ===== test/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin err_total++; \
  $display("MISMATCH t=%0t got %0h exp %0h", $time, g, e); end end
module tb_top;
  import etc_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  etc_reg_req_s reg_req;
  etc_line_res_s line_res = '0;
  logic [15:0] reg_rdata, tx_wire_len, st;
  logic [15:0] buf_free = 16'h0C00;
  logic data_wr = 1'b0, data_late = 1'b0, pulse_valid = 1'b0, pulse_bad = 1'b0;
  logic crs_in = 1'b0, col_in = 1'b0;
  logic tx_irq, tx_go, tx_add_crc, tx_flush, data_accept, link_good;
  logic link_pulse_en, enc_to_dec, line_drv_en, col_seen;
  int err_total = 0, n_compared = 0, n_irq = 0, n_flush = 0, i, k;
  int exp_q[$];
  bit lb = 1'b0; // bench has put the block in loopback
  int lens[12];
  always #2 clk_sys = ~clk_sys;
  // one-cycle outputs are counted so a late look cannot miss them
  always @(posedge clk_sys) begin
    n_irq += (tx_irq === 1'b1);
    n_flush += (tx_flush === 1'b1);
  end
  etc_tx_ctrl i_etc_tx_ctrl (.clk_sys(clk_sys), .rst_b(rst_b),
    .reg_req(reg_req), .reg_rdata(reg_rdata), .buf_free(buf_free),
    .data_wr(data_wr), .data_late(data_late), .line_res(line_res),
    .pulse_valid(pulse_valid), .pulse_bad(pulse_bad), .crs_in(crs_in),
    .col_in(col_in), .tx_irq(tx_irq), .tx_go(tx_go),
    .tx_wire_len(tx_wire_len), .tx_add_crc(tx_add_crc), .tx_flush(tx_flush),
    .data_accept(data_accept), .link_good(link_good),
    .link_pulse_en(link_pulse_en), .enc_to_dec(enc_to_dec),
    .line_drv_en(line_drv_en), .col_seen(col_seen));
  etc_host_model i_etc_host_model (.clk_sys(clk_sys), .reg_req(reg_req),
    .reg_rdata(reg_rdata));
  ////////////////////////////////////////////////////////////////////////////
  // reference wire length, 0 when the bid is refused
  function automatic int ref_len(int l, bit pd, bit ci);
    if (l < 3 || l > 1518 || (l > 1514 && !ci)) return 0;
    return (l < 60 && !pd) ? 60 : l;
  endfunction
  task automatic conclude();
    $display("compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic fail();
    err_total++;
    conclude();
  endtask
  task automatic pulse(bit good);
    @(negedge clk_sys);
    pulse_valid <= good;
    pulse_bad <= !good;
    @(negedge clk_sys);
    pulse_valid <= 1'b0;
    pulse_bad <= 1'b0;
  endtask
  // one whole frame; fault 0 ok, 1..3 line failures, 4 underrun
  task automatic bid(int l, bit pd, bit ci, int fault);
    logic [15:0] cmd, ev;
    int x, n, irq0, pos;
    x = ref_len(l, pd, ci);
    cmd = 16'h0000;
    cmd[ETC_B_PAD_DIS] = pd;
    cmd[ETC_B_CRC_INH] = ci;
    i_etc_host_model.request(cmd, 16'(l), st);
    `CHK(st[ETC_B_READY], x != 0)
    `CHK(st[ETC_B_BID_ERR], x == 0)
    `CHK(data_accept, x != 0)
    if (x == 0) return;
    exp_q.push_back(x);
    for (n = 0; n < 2000 && tx_go !== 1'b1; n++) begin
      data_wr <= 1'b1;
      @(negedge clk_sys);
    end
    data_wr <= 1'b0;
    if (n == 2000) fail();
    `CHK(tx_wire_len, 16'(exp_q.pop_front()))
    `CHK(tx_add_crc, !ci)
    irq0 = n_irq;
    @(negedge clk_sys);
    `CHK(col_seen, crs_in && !lb)
    line_res <= '{fault < 4, fault == 0, fault == 1, fault == 2, fault == 3};
    data_late <= (fault == 4);
    @(negedge clk_sys);
    line_res <= '0;
    data_late <= 1'b0;
    repeat (3) @(negedge clk_sys);
    `CHK(data_accept, 1'b0)
    `CHK(n_irq > irq0, fault == 0)
    pos = fault == 0 ? ETC_B_TX_OK : fault == 1 ? ETC_B_EXCOLL :
          fault == 2 ? ETC_B_JABBER : fault == 3 ? ETC_B_LATE : ETC_B_UNDERRUN;
    i_etc_host_model.rd(fault == 4 ? ETC_OFS_BUF_EVENT : ETC_OFS_TX_EVENT, ev);
    `CHK(ev[pos], 1'b1)
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // each frame completes before the next bid is made
  initial begin
    repeat (3) @(negedge clk_sys);
    `CHK(link_pulse_en, 1'b1)
    `CHK(line_drv_en, 1'b1)
    `CHK(data_accept, 1'b0)
    rst_b <= 1'b1;
    void'($urandom(2));
    i_etc_host_model.wr(ETC_OFS_TX_CFG, 16'h0100);
    lens = '{2, 3, 59, 60, 1514, 1515, 1518, 1519, 0, 0, 0, 0};
    for (k = 0; k < 4; k++) begin
      lens[8] = 3 + $urandom % 57;
      lens[9] = 61 + $urandom % 1453;
      lens[10] = 1515 + $urandom % 3;
      lens[11] = 1519 + $urandom % 4000;
      foreach (lens[j]) bid(lens[j], k[1], k[0], 0);
    end
    for (k = 1; k < 5; k++) bid(100, 1'b0, 1'b0, k);
    // poll mode: no room at the bid, room appears later, then abort
    buf_free <= 16'h000A;
    i_etc_host_model.request(16'h0000, 16'h0064, st);
    `CHK(st[ETC_B_READY], 1'b0)
    `CHK(data_accept, 1'b0)
    buf_free <= 16'h0C00;
    for (i = 0; i < 20 && st[ETC_B_READY] !== 1'b1; i++)
      i_etc_host_model.rd(ETC_OFS_BUS_ST, st);
    if (i == 20) fail();
    `CHK(st[ETC_B_READY], 1'b1)
    `CHK(data_accept, 1'b1)
    k = n_flush;
    i_etc_host_model.abort();
    `CHK(n_flush > k, 1'b1)
    `CHK(data_accept, 1'b0)
    // interrupt mode: room is announced by the ready event
    i_etc_host_model.wr(ETC_OFS_BUF_CFG, 16'h0100);
    buf_free <= 16'h000A;
    i_etc_host_model.request(16'h0000, 16'h0064, st);
    `CHK(st[ETC_B_READY], 1'b0)
    k = n_irq;
    buf_free <= 16'h0C00;
    for (i = 0; i < 50 && n_irq == k; i++) @(negedge clk_sys);
    if (i == 50) fail();
    `CHK(n_irq > k, 1'b1)
    i_etc_host_model.rd(ETC_OFS_BUF_EVENT, st);
    `CHK(st[ETC_B_READY], 1'b1)
    `CHK(data_accept, 1'b1)
    i_etc_host_model.abort();
    i_etc_host_model.wr(ETC_OFS_BUF_CFG, 16'h0000);
    // a bad pulse restarts the count of valid ones
    repeat (3) pulse(1'b1);
    pulse(1'b0);
    repeat (3) pulse(1'b1);
    `CHK(link_good, 1'b0)
    pulse(1'b1);
    @(negedge clk_sys);
    `CHK(link_good, 1'b1)
    i_etc_host_model.wr(ETC_OFS_TEST_CTL, 16'h0200);
    crs_in <= 1'b1;
    repeat (2) @(negedge clk_sys);
    `CHK(enc_to_dec, 1'b1)
    `CHK(line_drv_en, 1'b0)
    `CHK(col_seen, 1'b0)
    // a whole frame in loopback with carrier up must see no collision
    lb = 1'b1;
    bid(100, 1'b0, 1'b0, 0);
    i_etc_host_model.wr(ETC_OFS_TEST_CTL, 16'h0100);
    @(negedge clk_sys);
    `CHK(link_pulse_en, 1'b0)
    conclude();
  end
endmodule // tb_top
`default_nettype wire
